// File: inc/led_cplx_map.svh
`ifndef LED_CPLX_MAP_SVH
`define LED_CPLX_MAP_SVH

// ----------------------------------------
// register indices and reset values
// ----------------------------------------
`define IDX_CFG_A      2'h0
`define IDX_CFG_B      2'h1
`define IDX_STATUS     2'h2
`define CFG_A_RST      16'h0000
`define CFG_B_RST      16'h0000
`define CFG_A_MASK     16'h00F7
`define CFG_B_MASK     16'h0077

// ----------------------------------------
// field positions
// ----------------------------------------
`define FAST_RATE_HI   7
`define FAST_RATE_LO   6
`define SLOW_RATE_HI   5
`define SLOW_RATE_LO   4
`define REV_HI         2
`define REV_LO         0
`define SWP_HI         6
`define SWP_LO         4
`define FLS_HI         2
`define FLS_LO         0

// ----------------------------------------
// array size and timing
// ----------------------------------------
`define LED_NUM        4
`define CLK_HZ         25000000
`define FAST_MAX_HZ    16
`define TICK_CYC       (`CLK_HZ / (2 * `FAST_MAX_HZ))
`define STRETCH_TICKS  2'h2

`endif

// File: inc/led_cplx_pkg.sv
`include "led_cplx_map.svh"

package led_cplx_pkg;

  typedef enum logic [2:0] {
    trig_none                    = 3'b000,
    trig_link_up                 = 3'b001,
    trig_powered_down_state      = 3'b010,
    trig_eee_active              = 3'b011,
    trig_autoneg_running_state   = 3'b100,
    trig_analog_selftest_state   = 3'b101,
    trig_cable_diagnostics_state = 3'b110,
    trig_test_running            = 3'b111
  } trig_t;

  typedef enum logic [1:0] {
    rate_two_hz     = 2'b00,
    rate_four_hz    = 2'b01,
    rate_eight_hz   = 2'b10,
    rate_sixteen_hz = 2'b11
  } rate_t;

  typedef enum logic [1:0] {
    cplx_none    = 2'b00,
    cplx_flash   = 2'b01,
    cplx_sweep   = 2'b10,
    cplx_reverse = 2'b11
  } cplx_t;

  typedef struct packed {
    logic link_up;
    logic powered_down_state;
    logic eee_active;
    logic autoneg_running_state;
    logic analog_selftest_state;
    logic cable_diagnostics_state;
    logic test_running;
  } phy_state_t;

  typedef struct packed {
    logic        en;
    logic        wr;
    logic [1:0]  idx;
    logic [15:0] wdata;
  } mgmt_req_t;

  typedef struct packed {
    logic [`LED_NUM-1:0] pulse;
    logic [`LED_NUM-1:0] slow;
    logic [`LED_NUM-1:0] fast;
    logic [`LED_NUM-1:0] con;
  } direct_led_t;

endpackage

// File: logic/complex_led_pattern_control.sv
// Overview of operation
// - an active complex function overrides every direct setting on all LEDs.
// - a triggered complex function drives the whole LED array with its pattern.
// - phy state is compared continuously with each trigger; on matches flash wins over sweep, sweep over inverse sweep.
// - config_a bits 7:6 pick the fast blink rate 2, 4, 8 or 16 Hz.
// - the pulse stretch width follows the fast blink rate.
// - config_a bits 5:4 pick the slow blink rate 2, 4, 8 or 16 Hz.
// - config_a bits 2:0 pick the state that starts the inverse sweep.
// - config_b bits 6:4 pick the state that starts the back and forth sweep.
// - sweep steps and flash toggles run at the fast blink rate.
// - config_b bits 2:0 pick the state that flashes all LEDs in phase at fast rate.
// - trigger codes 000..011 mean none, link up, powered down, eee active.
// - trigger codes 100..111 mean autoneg, self-test, cable diagnostics, test mode.
// - without a complex function each LED resolves pulse, slow, fast, constant on.
`include "led_cplx_map.svh"

module complex_led_pattern_control #(
  parameter int TICK_CYC = `TICK_CYC            // half period of the 16 Hz wave
) (
  input  wire logic                       clk,        // 25 MHz system clock
  input  wire logic                       arst_n,     // async reset, active low
  input  wire led_cplx_pkg::phy_state_t   phy_state,  // phy state indications
  input  wire led_cplx_pkg::direct_led_t  direct_led, // direct function requests
  input  wire led_cplx_pkg::mgmt_req_t    mgmt_req,   // register access request
  output logic [15:0]                     mgmt_rdata, // read data, registered
  output logic                            mgmt_rvalid,// read data valid pulse
  output logic [`LED_NUM-1:0]             led_out     // led drive, high is lit
);

  // ----------------------------------------
  // registers
  // ----------------------------------------
  logic [15:0] cfg_a_reg;
  logic [15:0] cfg_b_reg;
  logic [15:0] rd_next;
  wire         wr_a = mgmt_req.en && mgmt_req.wr && (mgmt_req.idx == `IDX_CFG_A);
  wire         wr_b = mgmt_req.en && mgmt_req.wr && (mgmt_req.idx == `IDX_CFG_B);
  wire         rd   = mgmt_req.en && !mgmt_req.wr;

  wire led_cplx_pkg::rate_t fast_blink_rate =
    led_cplx_pkg::rate_t'(cfg_a_reg[`FAST_RATE_HI:`FAST_RATE_LO]);
  wire led_cplx_pkg::rate_t slow_blink_rate =
    led_cplx_pkg::rate_t'(cfg_a_reg[`SLOW_RATE_HI:`SLOW_RATE_LO]);
  wire led_cplx_pkg::trig_t rev_t = led_cplx_pkg::trig_t'(cfg_a_reg[`REV_HI:`REV_LO]);
  wire led_cplx_pkg::trig_t swp_t = led_cplx_pkg::trig_t'(cfg_b_reg[`SWP_HI:`SWP_LO]);
  wire led_cplx_pkg::trig_t fls_t = led_cplx_pkg::trig_t'(cfg_b_reg[`FLS_HI:`FLS_LO]);

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      cfg_a_reg <= `CFG_A_RST;
      cfg_b_reg <= `CFG_B_RST;
    end
    else
    begin
      if (wr_a)
        cfg_a_reg <= mgmt_req.wdata & `CFG_A_MASK;
      if (wr_b)
        cfg_b_reg <= mgmt_req.wdata & `CFG_B_MASK;
    end
  end

  // ----------------------------------------
  // timebase
  // ----------------------------------------
  // one divider feeds every rate, so all waves stay phase locked
  logic [19:0] div_reg;
  logic [3:0]  phase_reg;
  wire         tick     = (div_reg == 20'(TICK_CYC - 1));
  wire [2:0]   step_req = 3'h7 >> fast_blink_rate;
  wire         fast_step = tick && ((phase_reg[2:0] & step_req) == step_req);
  wire         fast_lvl = phase_reg[2'h3 - fast_blink_rate];
  wire         slow_lvl = phase_reg[2'h3 - slow_blink_rate];

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      div_reg   <= 20'h00000;
      phase_reg <= 4'h0;
    end
    else
    begin
      div_reg <= tick ? 20'h00000 : div_reg + 20'h00001;
      if (tick)
        phase_reg <= phase_reg + 4'h1;
    end
  end

  // ----------------------------------------
  // trigger decode
  // ----------------------------------------
  function automatic logic state_match(led_cplx_pkg::trig_t t, led_cplx_pkg::phy_state_t s);
    case (t)
      led_cplx_pkg::trig_none:                    state_match = 1'b0;
      led_cplx_pkg::trig_link_up:                 state_match = s.link_up;
      led_cplx_pkg::trig_powered_down_state:      state_match = s.powered_down_state;
      led_cplx_pkg::trig_eee_active:              state_match = s.eee_active;
      led_cplx_pkg::trig_autoneg_running_state:   state_match = s.autoneg_running_state;
      led_cplx_pkg::trig_analog_selftest_state:   state_match = s.analog_selftest_state;
      led_cplx_pkg::trig_cable_diagnostics_state: state_match = s.cable_diagnostics_state;
      led_cplx_pkg::trig_test_running:            state_match = s.test_running;
      default:                                    state_match = 1'b0;
    endcase
  endfunction

  wire fls_on = state_match(fls_t, phy_state);
  wire swp_on = state_match(swp_t, phy_state);
  wire rev_on = state_match(rev_t, phy_state);
  wire led_cplx_pkg::cplx_t act =
    fls_on ? led_cplx_pkg::cplx_flash :
    swp_on ? led_cplx_pkg::cplx_sweep :
    rev_on ? led_cplx_pkg::cplx_reverse : led_cplx_pkg::cplx_none;

  // ----------------------------------------
  // sweep position
  // ----------------------------------------
  // restarts at the first led each time a sweep is entered from flash or none; a switch between the two sweeps keeps the position
  logic [1:0] pos_reg;
  logic       dir_reg;
  wire        sweeping = (act == led_cplx_pkg::cplx_sweep) || (act == led_cplx_pkg::cplx_reverse);
  wire        at_last  = (pos_reg == 2'(`LED_NUM - 1));
  wire        at_first = (pos_reg == 2'h0);

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      pos_reg <= 2'h0;
      dir_reg <= 1'b0;
    end
    else if (!sweeping)
    begin
      pos_reg <= 2'h0;
      dir_reg <= 1'b0;
    end
    else if (fast_step)
    begin
      if (!dir_reg)
      begin
        dir_reg <= at_last;
        pos_reg <= at_last ? pos_reg - 2'h1 : pos_reg + 2'h1;
      end
      else
      begin
        dir_reg <= !at_first;
        pos_reg <= at_first ? pos_reg + 2'h1 : pos_reg - 2'h1;
      end
    end
  end

  wire [`LED_NUM-1:0] run_bit = `LED_NUM'(1) << pos_reg;

  // ----------------------------------------
  // direct functions
  // ----------------------------------------
  logic [`LED_NUM-1:0] stretched;
  logic [`LED_NUM-1:0] direct_lvl;

  for (genvar i = 0; i < `LED_NUM; i++)
  begin : g_led
    logic [1:0] str_reg;
    // stretch counts fast steps, so its width tracks the fast rate
    always_ff @(posedge clk or negedge arst_n)
    begin
      if (!arst_n)
        str_reg <= 2'h0;
      else if (direct_led.pulse[i])
        str_reg <= `STRETCH_TICKS;
      else if (fast_step && (str_reg != 2'h0))
        str_reg <= str_reg - 2'h1;
    end
    assign stretched[i]  = (str_reg != 2'h0) || direct_led.pulse[i];
    assign direct_lvl[i] = stretched[i]          ? 1'b1 :
                           direct_led.slow[i]    ? slow_lvl :
                           direct_led.fast[i]    ? fast_lvl :
                           direct_led.con[i];
  end

  // ----------------------------------------
  // output select and read back
  // ----------------------------------------
  logic [`LED_NUM-1:0] led_next;
  always_comb
  begin
    case (act)
      led_cplx_pkg::cplx_flash:   led_next = {`LED_NUM{fast_lvl}};
      led_cplx_pkg::cplx_sweep:   led_next = run_bit;
      led_cplx_pkg::cplx_reverse: led_next = ~run_bit;
      default:                    led_next = direct_lvl;
    endcase
  end

  assign rd_next = (mgmt_req.idx == `IDX_CFG_A)  ? cfg_a_reg :
                   (mgmt_req.idx == `IDX_CFG_B)  ? cfg_b_reg :
                   (mgmt_req.idx == `IDX_STATUS) ? {12'h000, act, pos_reg} : 16'h0000;

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      led_out     <= '0;
      mgmt_rdata  <= 16'h0000;
      mgmt_rvalid <= 1'b0;
    end
    else
    begin
      led_out     <= led_next;
      mgmt_rvalid <= rd;
      if (rd)
        mgmt_rdata <= rd_next;
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  flash_all_a: assert property (@(posedge clk) disable iff (!arst_n)
    fls_on |=> (led_out == {`LED_NUM{$past(fast_lvl)}}))
    else $error("flash pattern not applied to all leds");
  flash_first_a: assert property (@(posedge clk) disable iff (!arst_n)
    (fls_on && swp_on) |-> (act == led_cplx_pkg::cplx_flash))
    else $error("flash lost precedence");
  sweep_one_a: assert property (@(posedge clk) disable iff (!arst_n)
    (act == led_cplx_pkg::cplx_sweep) |=> $onehot(led_out))
    else $error("sweep not one hot");
  reverse_pat_a: assert property (@(posedge clk) disable iff (!arst_n)
    (act == led_cplx_pkg::cplx_reverse) |=> $onehot(~led_out))
    else $error("inverse sweep not one dark");
  direct_yield_a: assert property (@(posedge clk) disable iff (!arst_n)
    (act != led_cplx_pkg::cplx_none) |=> (led_out ==
      (($past(act) == led_cplx_pkg::cplx_flash) ? {`LED_NUM{$past(fast_lvl)}} :
       ($past(act) == led_cplx_pkg::cplx_sweep) ? $past(run_bit) : ~$past(run_bit))))
    else $error("direct setting leaked through");
  none_code_a: assert property (@(posedge clk) disable iff (!arst_n)
    (fls_t == led_cplx_pkg::trig_none) |-> !fls_on)
    else $error("code 000 activated flash");
  divider_a: assert property (@(posedge clk) disable iff (!arst_n)
    // small divisors are legal for fast runs, so only three idle cycles are demanded
    tick |=> !tick [*3])
    else $error("divider ticked too early");
  step_rate_a: assert property (@(posedge clk) disable iff (!arst_n)
    (tick && fast_blink_rate == led_cplx_pkg::rate_sixteen_hz) |-> fast_step)
    else $error("sweep step missed a tick at the top rate");
  stretch_a: assert property (@(posedge clk) disable iff (!arst_n)
    (act == led_cplx_pkg::cplx_none && direct_led.pulse[0]) |=> led_out[0])
    else $error("pulse did not light led");
  slow_rate_a: assert property (@(posedge clk) disable iff (!arst_n)
    (act == led_cplx_pkg::cplx_none && direct_led.slow[0] && !stretched[0])
      |=> (led_out[0] == $past(slow_lvl)))
    else $error("slow blink level wrong");

endmodule

// File: verif/led_panel.sv
`include "led_cplx_map.svh"

// ----------------------------------------
// status leds on the phy pins
// ----------------------------------------
module led_panel (
  input  wire logic [`LED_NUM-1:0] led_out,   // pin levels, high is lit
  output logic [2:0]               lit_count, // number of lit leds
  output logic                     uniform    // all leds show one level
);
  timeunit 1ns;
  timeprecision 1ps;

  assign lit_count = 3'(led_out[0]) + 3'(led_out[1]) + 3'(led_out[2]) + 3'(led_out[3]);
  assign uniform   = (led_out == 4'h0) || (led_out == 4'hF);
endmodule

// File: verif/complex_led_pattern_control_tb.sv
`include "led_cplx_map.svh"

module complex_led_pattern_control_tb;
  timeunit 1ns;
  timeprecision 1ps;

  localparam int TC = 4;
  logic                      clk        = 1'b0;
  logic                      arst_n     = 1'b0;
  led_cplx_pkg::phy_state_t  phy_state  = '0;
  led_cplx_pkg::direct_led_t direct_led = '0;
  led_cplx_pkg::mgmt_req_t   mgmt_req   = '0;
  logic [15:0]               mgmt_rdata;
  logic                      mgmt_rvalid;
  logic [`LED_NUM-1:0]       led_out;
  logic [2:0]                lit_count;
  logic                      uniform;
  int                        n_mismatch = 0;
  int                        checked    = 0;
  int                        cycles     = 0;
  int                        ma         = 0;
  int                        mb         = 0;
  int                        hp;
  int                        odd;

  complex_led_pattern_control #(.TICK_CYC(TC)) i_dut (.clk(clk), .arst_n(arst_n),
    .phy_state(phy_state), .direct_led(direct_led), .mgmt_req(mgmt_req),
    .mgmt_rdata(mgmt_rdata), .mgmt_rvalid(mgmt_rvalid), .led_out(led_out));
  led_panel i_panel (.led_out(led_out), .lit_count(lit_count), .uniform(uniform));

  always #20 clk = ~clk;

  // ----------------------------------------
  // hang guard, far above the planned run
  // ----------------------------------------
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 30000)
    begin
      n_mismatch++;
      wrap_up();
    end
  end

  // ----------------------------------------
  // compare and bus tasks
  // ----------------------------------------
  task automatic wrap_up();
    $display("checked %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic chk_word(input string name, input logic [15:0] exp, input logic [15:0] got);
    checked++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic chk_cnt(input string name, input int exp, input int got);
    checked++;
    if (got != exp)
    begin
      n_mismatch++;
      $display("[ERR] %s expected %0d seen %0d", name, exp, got);
    end
  endtask

  task automatic reg_wr(input logic [1:0] idx, input logic [15:0] data);
    @(posedge clk);
    mgmt_req <= '{en: 1'b1, wr: 1'b1, idx: idx, wdata: data};
    @(posedge clk);
    mgmt_req.en <= 1'b0;
    if (idx == 2'h0)
      ma = data & `CFG_A_MASK;
    if (idx == 2'h1)
      mb = data & `CFG_B_MASK;
  endtask

  task automatic reg_rd(input logic [1:0] idx, input logic [15:0] exp, input logic [15:0] m);
    @(posedge clk);
    mgmt_req <= '{en: 1'b1, wr: 1'b0, idx: idx, wdata: 16'h0000};
    @(posedge clk);
    mgmt_req.en <= 1'b0;
    @(posedge clk);
    chk_word("rvalid", 16'h0001, {15'h0000, mgmt_rvalid});
    chk_word("rdata", exp, mgmt_rdata & m);
  endtask

  // skips entry, the first partial step and one full step, then times the next full step
  task automatic half_period(input int mode, output int n, output int bad);
    logic [3:0] last;
    int         i;
    int         j;
    n = 0;
    bad = 0;
    @(posedge clk);
    for (j = 0; j < 3; j++)
    begin
      last = led_out;
      n = 0;
      for (i = 0; i < 600 && led_out === last; i++)
      begin
        @(posedge clk);
        n++;
        if ((mode == 1 && !uniform) || (mode == 2 && lit_count != 3'h1) ||
            (mode == 3 && lit_count != 3'h3))
          bad++;
      end
    end
  endtask

  // ----------------------------------------
  // reference of the active complex function
  // ----------------------------------------
  function automatic bit hit(input int code, input logic [6:0] st);
    return code != 0 && st[7 - code] === 1'b1;
  endfunction

  function automatic logic [15:0] active(input logic [6:0] st);
    if (hit(mb & 7, st))
      return 16'h0004;
    if (hit((mb >> 4) & 7, st))
      return 16'h0008;
    if (hit(ma & 7, st))
      return 16'h000C;
    return 16'h0000;
  endfunction

  initial
  begin
    void'($urandom(32'hD23BAC5C));
    repeat (12) @(posedge clk);
    arst_n <= 1'b1;
    reg_rd(2'h0, 16'h0000, 16'hFFFF);
    reg_rd(2'h1, 16'h0000, 16'hFFFF);
    reg_rd(2'h3, 16'h0000, 16'hFFFF);
    for (int k = 0; k < 4; k++)
    begin
      reg_wr(2'h0, 16'($urandom));
      reg_wr(2'h1, 16'($urandom));
      reg_wr(2'h2, 16'($urandom));
      reg_rd(2'h0, 16'(ma), 16'hFFFF);
      reg_rd(2'h1, 16'(mb), 16'hFFFF);
    end
    reg_wr(2'h1, 16'h0000);
    direct_led.con <= 4'($urandom);
    repeat (3) @(posedge clk);
    chk_word("direct con", {12'h000, direct_led.con}, {12'h000, led_out});
    direct_led <= '{pulse: 4'hF, slow: 4'hF, fast: 4'hF, con: 4'h0};
    repeat (3) @(posedge clk);
    chk_word("pulse first", 16'h000F, {12'h000, led_out});
    direct_led <= '{pulse: 4'h0, slow: 4'hF, fast: 4'h0, con: 4'hF};
    for (int s = 0; s < 4; s++)
    begin
      reg_wr(2'h0, 16'(s << 4));
      half_period(1, hp, odd);
      chk_cnt("slow half period", TC << (3 - s), hp);
    end
    phy_state.link_up <= 1'b1;
    reg_wr(2'h1, 16'h0001);
    for (int f = 0; f < 4; f++)
    begin
      reg_wr(2'h0, 16'(f << 6));
      half_period(1, hp, odd);
      chk_cnt("flash half period", TC << (3 - f), hp);
      chk_cnt("flash out of phase", 0, odd);
    end
    reg_wr(2'h0, 16'h0000);
    for (int c = 1; c < 8; c++)
    begin
      reg_wr(2'h1, 16'(c));
      phy_state <= 7'(1 << (7 - c));
      repeat (2) @(posedge clk);
      reg_rd(2'h2, active(phy_state), 16'h000C);
      phy_state <= 7'(1 << (c % 7));
      repeat (2) @(posedge clk);
      reg_rd(2'h2, active(phy_state), 16'h000C);
    end
    phy_state <= 7'h40;
    reg_wr(2'h0, 16'h0081);
    reg_wr(2'h1, 16'h0011);
    reg_rd(2'h2, active(phy_state), 16'h000C);
    reg_wr(2'h1, 16'h0010);
    reg_rd(2'h2, active(phy_state), 16'h000C);
    half_period(2, hp, odd);
    chk_cnt("sweep step", TC << 1, hp);
    chk_cnt("sweep lit", 0, odd);
    reg_wr(2'h1, 16'h0000);
    reg_rd(2'h2, active(phy_state), 16'h000C);
    half_period(3, hp, odd);
    chk_cnt("inverse step", TC << 1, hp);
    chk_cnt("inverse lit", 0, odd);
    // stretch lasts two fast steps, the first one partial
    direct_led <= '0;
    for (int f = 0; f < 4; f += 3)
    begin
      reg_wr(2'h0, 16'(f << 6));
      direct_led.pulse <= 4'h1;
      @(posedge clk);
      direct_led.pulse <= 4'h0;
      hp = 0;
      @(posedge clk);
      while (led_out[0] === 1'b1 && hp < 600)
      begin
        hp++;
        @(posedge clk);
      end
      chk_cnt("stretch span", 1,
        int'(hp >= (TC << (3 - f)) + 2 && hp <= (TC << (4 - f)) + 1));
    end
    arst_n <= 1'b0;
    repeat (2) @(posedge clk);
    arst_n <= 1'b1;
    reg_rd(2'h0, 16'h0000, 16'hFFFF);
    chk_word("led after reset", 16'h0000, {12'h000, led_out});
    wrap_up();
  end
endmodule
